// *** include/boot_entry_pkg.sv ***
// Constants for the boot ROM entry control block
package boot_entry_pkg;
  localparam logic [5:0] KEY_PATTERN = 6'h26;
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 2;
  localparam logic [3:0] UNLOCK_CYCLES = 4'h8;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [1:0] HV_HOLD_CYCLES = 2'h3;
  localparam logic [3:0] DEBOUNCE_CYCLES = 4'hF;
  localparam logic [1:0] LOAD_CLK_DIV = 2'h1;
  localparam logic FLEX_RESET = 1'b0;
  localparam logic SECURITY_RESET = 1'b0;
endpackage

// *** verilog/boot_rom_entry_control.sv ***
// Boot ROM entry control: key window, jump/return steering, forced boot entry
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Jump-to-boot enters boot ROM only while the unlock flag is set.
// - Key is 100110 in bits 7..2; bits 1..0 ignored.
// - Wrong key leaves flag clear; jump-to-boot then stays in flash.
// - Breakpoint in emulation freezes the window counter while flag set.
// - Window keeps counting during interrupt servicing.
// - Return-to-flash moves execution from boot ROM to flash.
// - No flash execution while flash is being programmed; run from boot ROM.
// - High voltage on force pin at reset ignores flash-execute bit, boots ROM 0000.
// - Later plain reset starts flash 0000 unless flash-execute bit erased.
// - Forced boot never alters flash-execute or security bits.
// - Security bit clears only on mass erase, except user-level erase.
// - While force pin is high voltage, load clock drives the load clock pin.
// - Force pin reads one while high; boot waits low, debounces, enables ISP.
// - Reset with flash-execute one and no force starts flash address 0000.
module boot_rom_entry_control
#(
  parameter int CNT_W = 4
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic keyWrite,
  input wire logic [7:0] keyWriteData,
  input wire logic jumpToBootInstr,
  input wire logic returnToFlashInstr,
  input wire logic emulationMode,
  input wire logic breakpointHit,
  input wire logic flashProgramming,
  input wire logic hvForcePinHigh,
  input wire logic hvForcePinLevel,
  input wire logic massErase,
  input wire logic pageEraseOption,
  input wire logic userIspErase,
  input wire logic optionWrite,
  input wire logic optionFlexIn,
  input wire logic optionSecurityIn,
  output logic keyUnlocked,
  output logic execFromBoot,
  output logic [15:0] resetVector,
  output logic jumpIntoBoot,
  output logic jumpInFlash,
  output logic flashFetchBlocked,
  output logic forcedBoot,
  output logic forcePinRead,
  output logic ispEnable,
  output logic loadClockPinOut,
  output logic loadClockPinOe,
  output logic flexBit,
  output logic securityBit
);

  logic [CNT_W-1:0] windowCnt_q;
  logic unlock_q;
  logic bootMode_q;
  logic inReset_q;
  logic forced_q;
  // Option bits model non-volatile cells: power-up value only, reset leaves them alone
  logic flex_q = boot_entry_pkg::FLEX_RESET;
  logic sec_q = boot_entry_pkg::SECURITY_RESET;
  logic [1:0] hvHold_q;
  logic [3:0] debounce_q;
  logic isp_q;
  logic [1:0] divCnt_q;
  logic loadClk_q;
  logic oe_q;
  logic jumpBoot_q;
  logic jumpFlash_q;
  logic blocked_q;
  logic pinRead_q;
  logic [15:0] vector_q;
  logic keyMatch;
  logic freeze;
  logic enterBoot;

  assign keyMatch = keyWrite &&
    (keyWriteData[boot_entry_pkg::KEY_MSB:boot_entry_pkg::KEY_LSB]
     == boot_entry_pkg::KEY_PATTERN);
  // Interrupts are not an input here, so the window never pauses for them
  assign freeze = emulationMode && breakpointHit && unlock_q;
  assign enterBoot = jumpToBootInstr && unlock_q;

  // Unlock window counter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      unlock_q <= 1'b0;
      windowCnt_q <= '0;
    end
    else if (keyMatch)
    begin
      unlock_q <= 1'b1;
      windowCnt_q <= CNT_W'(boot_entry_pkg::UNLOCK_CYCLES - 4'h1);
    end
    else if (freeze)
    begin
      windowCnt_q <= windowCnt_q;
    end
    else if (unlock_q)
    begin
      if (windowCnt_q == '0)
      begin
        unlock_q <= 1'b0;
      end
      else
      begin
        windowCnt_q <= windowCnt_q - CNT_W'(1);
      end
    end
  end
  // A wrong key simply never reaches the set branch above

  // Reset tracking: forced boot is sampled at the release edge, not under reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inReset_q <= 1'b1;
      forced_q <= 1'b0;
    end
    else
    begin
      inReset_q <= 1'b0;
      if (inReset_q)
      begin
        forced_q <= hvForcePinHigh;
      end
    end
  end

  // Execution space
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bootMode_q <= 1'b0;
      vector_q <= boot_entry_pkg::RESET_VECTOR;
      jumpBoot_q <= 1'b0;
      jumpFlash_q <= 1'b0;
    end
    else
    begin
      jumpBoot_q <= enterBoot;
      jumpFlash_q <= jumpToBootInstr && !unlock_q;
      if (inReset_q)
      begin
        // Flash-execute bit clear also lands in boot ROM, so an erased part is programmable
        bootMode_q <= hvForcePinHigh || !flex_q;
        vector_q <= boot_entry_pkg::RESET_VECTOR;
      end
      else if (enterBoot)
      begin
        bootMode_q <= 1'b1;
      end
      else if (returnToFlashInstr && bootMode_q)
      begin
        bootMode_q <= 1'b0;
      end
    end
  end

  // Flash fetch is blocked while programming; caller must already be in boot ROM
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      blocked_q <= 1'b0;
    end
    else
    begin
      blocked_q <= flashProgramming;
    end
  end

  // Option bits: forced entry has no path into them
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flex_q <= flex_q;
      sec_q <= sec_q;
    end
    else if (massErase)
    begin
      flex_q <= 1'b0;
      sec_q <= 1'b0;
    end
    else if (optionWrite)
    begin
      flex_q <= optionFlexIn;
      // Security can be set freely but only a user-level routine may clear it
      sec_q <= optionSecurityIn | (sec_q & !userIspErase);
    end
    else if (pageEraseOption)
    begin
      flex_q <= 1'b0;
      if (userIspErase)
      begin
        sec_q <= 1'b0;
      end
    end
  end
  // hvForcePinHigh is not used in the block above

  // Load clock on the load clock pin while high voltage present
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      divCnt_q <= '0;
      loadClk_q <= 1'b0;
    end
    else if (hvForcePinHigh)
    begin
      if (divCnt_q == boot_entry_pkg::LOAD_CLK_DIV)
      begin
        divCnt_q <= '0;
        loadClk_q <= !loadClk_q;
      end
      else
      begin
        divCnt_q <= divCnt_q + 2'h1;
      end
    end
    else
    begin
      divCnt_q <= '0;
      loadClk_q <= 1'b0;
    end
  end

  // Load clock pin is driven for as long as high voltage is present
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= hvForcePinHigh;
    end
  end

  // Force pin read, hold count and debounce before ISP enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinRead_q <= 1'b0;
      hvHold_q <= '0;
      debounce_q <= '0;
      isp_q <= 1'b0;
    end
    else
    begin
      pinRead_q <= hvForcePinHigh || hvForcePinLevel;
      if (hvForcePinHigh && hvHold_q != boot_entry_pkg::HV_HOLD_CYCLES)
      begin
        hvHold_q <= hvHold_q + 2'h1;
      end
      if (!forced_q || isp_q)
      begin
        debounce_q <= '0;
      end
      else if (hvForcePinHigh || hvForcePinLevel)
      begin
        debounce_q <= '0;
      end
      else if (debounce_q == boot_entry_pkg::DEBOUNCE_CYCLES)
      begin
        isp_q <= 1'b1;
      end
      else
      begin
        debounce_q <= debounce_q + 4'h1;
      end
    end
  end

  assign keyUnlocked = unlock_q;
  assign execFromBoot = bootMode_q;
  assign resetVector = vector_q;
  assign jumpIntoBoot = jumpBoot_q;
  assign jumpInFlash = jumpFlash_q;
  assign flashFetchBlocked = blocked_q;
  assign forcedBoot = forced_q;
  assign forcePinRead = pinRead_q;
  assign ispEnable = isp_q;
  assign loadClockPinOut = loadClk_q;
  assign loadClockPinOe = oe_q;
  assign flexBit = flex_q;
  assign securityBit = sec_q;

endmodule // boot_rom_entry_control

`default_nettype wire

// *** tb/boot_entry_monitor.sv ***
// Assertion checker for the boot ROM entry control block
`timescale 1ns/10ps
`default_nettype none
module boot_entry_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic keyWrite,
  input wire logic [7:0] keyWriteData,
  input wire logic jumpToBootInstr,
  input wire logic emulationMode,
  input wire logic breakpointHit,
  input wire logic hvForcePinHigh,
  input wire logic keyUnlocked,
  input wire logic jumpIntoBoot,
  input wire logic jumpInFlash,
  input wire logic loadClockPinOut,
  input wire logic loadClockPinOe
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic keyOk = keyWrite && keyWriteData[7:2] == boot_entry_pkg::KEY_PATTERN;
  // Breakpoints stretch the window, so runs with one are left out
  wire logic calm = !keyWrite && !breakpointHit;
  sequence openRun;
    keyOk ##1 calm [*7];
  endsequence
  chk_key_sets:
    assert property (keyOk |=> keyUnlocked) else $error("no unlock");
  chk_bad_key:
    assert property (!keyUnlocked && !keyOk |=> !keyUnlocked) else $error("stray unlock");
  chk_window_open:
    assert property (openRun |=> keyUnlocked) else $error("window short");
  chk_window_close:
    assert property (openRun ##1 calm |-> ##1 !keyUnlocked) else $error("window long");
  chk_freeze_hold:
    assert property (emulationMode && breakpointHit && keyUnlocked |=> keyUnlocked) else $error("no hold");
  chk_jump_boot:
    assert property (jumpToBootInstr && keyUnlocked |=> jumpIntoBoot) else $error("no boot jump");
  chk_jump_flash:
    assert property (jumpToBootInstr && !keyUnlocked |=> jumpInFlash && !jumpIntoBoot) else $error("bad jump");
  chk_load_clock:
    assert property (hvForcePinHigh [*6] |-> loadClockPinOut != $past(loadClockPinOut, 2)) else $error("no load clock");
  chk_load_enable:
    assert property (hvForcePinHigh |=> loadClockPinOe) else $error("load pin not driven");
endmodule // boot_entry_monitor
bind boot_rom_entry_control boot_entry_monitor mon (.clk, .reset, .keyWrite, .keyWriteData,
  .jumpToBootInstr, .emulationMode, .breakpointHit, .hvForcePinHigh, .keyUnlocked,
  .jumpIntoBoot, .jumpInFlash, .loadClockPinOut, .loadClockPinOe);
`default_nettype wire

// *** tb/isp_host_model.sv ***
// Programming host that forces boot entry with high voltage on the force pin
`timescale 1ns/10ps
`default_nettype none
module isp_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic forceReq,
  output logic hvForcePinHigh,
  output logic hvForcePinLevel
);
  logic [3:0] hold_q = 4'h0;
  logic active_q = 1'b0;
  // Voltage only rises while reset is held; kept 8 cycles past release, above the minimum
  always_ff @(posedge clk)
  begin
    if (reset)
      hold_q <= 4'h0;
    else if (active_q)
      hold_q <= hold_q + 4'h1;
    if (reset && forceReq)
      active_q <= 1'b1;
    else if (!reset && hold_q == 4'h7)
      active_q <= 1'b0;
  end
  assign hvForcePinHigh = active_q;
  assign hvForcePinLevel = 1'b0;
endmodule // isp_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the boot ROM entry control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, reset = 1'b1, keyWrite = 1'b0, jumpToBootInstr = 1'b0, forceReq = 1'b0;
  logic returnToFlashInstr = 1'b0, emulationMode = 1'b0, breakpointHit = 1'b0, tieLow = 1'b0;
  logic flashProgramming = 1'b0, optionWrite = 1'b0, optionSecurityIn = 1'b0, optionFlexIn = 1'b0;
  logic flexBit;
  logic [7:0] keyWriteData = 8'h00;
  logic hvForcePinHigh, hvForcePinLevel, keyUnlocked, execFromBoot, jumpIntoBoot, jumpInFlash;
  logic flashFetchBlocked, forcedBoot, ispEnable, securityBit;
  int mismatches = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  isp_host_model host (.clk, .reset, .forceReq, .hvForcePinHigh, .hvForcePinLevel);
  boot_rom_entry_control DUT (.clk, .reset, .keyWrite, .keyWriteData, .jumpToBootInstr,
    .returnToFlashInstr, .emulationMode, .breakpointHit, .flashProgramming, .hvForcePinHigh,
    .hvForcePinLevel, .massErase(tieLow), .pageEraseOption(tieLow), .userIspErase(tieLow),
    .optionWrite, .optionFlexIn, .optionSecurityIn, .keyUnlocked, .execFromBoot,
    .resetVector(), .jumpIntoBoot, .jumpInFlash, .flashFetchBlocked, .forcedBoot,
    .forcePinRead(), .ispEnable, .loadClockPinOut(), .loadClockPinOe(), .flexBit, .securityBit);
  task complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task do_reset;
    @(posedge clk) reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask
  task wkey(input logic [7:0] d);
    @(posedge clk) keyWrite <= 1'b1;
    keyWriteData <= d;
    @(posedge clk) keyWrite <= 1'b0;
  endtask
  // Gap counts idle cycles between key write and jump; no interrupts run meanwhile
  task key_jump(input logic [7:0] d, input int gap, input logic boot);
    wkey(d);
    repeat (gap) @(posedge clk);
    jumpToBootInstr <= 1'b1;
    @(posedge clk) jumpToBootInstr <= 1'b0;
    #1;
    chk("jumpIntoBoot", boot, jumpIntoBoot);
    chk("jumpInFlash", !boot, jumpInFlash);
    chk("execFromBoot", boot, execFromBoot);
    @(posedge clk) returnToFlashInstr <= 1'b1;
    @(posedge clk) returnToFlashInstr <= 1'b0;
    #1;
    chk("execFromBoot", 1'b0, execFromBoot);
  endtask
  task t_keys;
    key_jump(8'h9B, 0, 1'b1);
    key_jump(8'h98, 7, 1'b1);
    key_jump(8'h98, 9, 1'b0);
    key_jump(8'h9C, 0, 1'b0);
    key_jump(8'h26, 0, 1'b0);
  endtask
  task t_rekey;
    wkey(8'h9A);
    repeat (5) @(posedge clk);
    key_jump(8'h99, 7, 1'b1);
  endtask
  task t_freeze;
    wkey(8'h98);
    emulationMode <= 1'b1;
    breakpointHit <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk("keyUnlocked", 1'b1, keyUnlocked);
    @(posedge clk) breakpointHit <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk("keyUnlocked", 1'b0, keyUnlocked);
  endtask
  task t_option;
    @(posedge clk) flashProgramming <= 1'b1;
    optionWrite <= 1'b1;
    optionSecurityIn <= 1'b1;
    optionFlexIn <= 1'b1;
    @(posedge clk) optionWrite <= 1'b0;
    flashProgramming <= 1'b0;
    #1;
    chk("flashFetchBlocked", 1'b1, flashFetchBlocked);
    chk("flexBit", 1'b1, flexBit);
    chk("securityBit", 1'b1, securityBit);
  endtask
  task t_forced;
    @(posedge clk) forceReq <= 1'b1;
    do_reset();
    forceReq <= 1'b0;
    #1;
    chk("forcedBoot", 1'b1, forcedBoot);
    chk("execFromBoot", 1'b1, execFromBoot);
    repeat (40) @(posedge clk);
    #1;
    chk("ispEnable", 1'b1, ispEnable);
    do_reset();
    #1;
    chk("forcedBoot", 1'b0, forcedBoot);
    chk("execFromBoot", 1'b0, execFromBoot);
    chk("securityBit", 1'b1, securityBit);
    chk("flexBit", 1'b1, flexBit);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    do_reset();
    t_keys();
    t_rekey();
    t_freeze();
    t_option();
    t_forced();
    complete_run();
  end
endmodule // tb
`default_nettype wire
